// file: dmac_pkg.sv
// Purpose: Shared constants and types for the multiply-accumulate unit
// Assumes: Single core clock, instruction decode drives the command port
// Notes: Selector encodings are local to this block
package dmac_pkg;
    localparam int DMAC_W = 16;
    localparam int DMAC_ACC_W = 40;
    localparam int DMAC_GUARD_W = 8;
    localparam int DMAC_MODE_W = 16;
    localparam int DMAC_BANK_BIT = 0;
    localparam int DMAC_INT_BIT = 4;
    localparam logic [15:0] DMAC_MODE_RESET = 16'h0000;
    localparam logic [15:0] DMAC_ROUND_MID = 16'h8000;
    localparam logic [39:0] DMAC_SAT_POS = 40'h007FFFFFFF;
    localparam logic [39:0] DMAC_SAT_NEG = 40'hFF80000000;
    localparam logic [39:0] DMAC_ROUND_ADD = 40'h0000008000;

    typedef enum logic [2:0] {
        DMAC_OP_NONE, DMAC_OP_MUL, DMAC_OP_MAC, DMAC_OP_MSUB, DMAC_OP_CLR, DMAC_OP_SAT
    } dmac_op_t;

    // X source: 0/1 operand regs, 2 result bus
    typedef enum logic [1:0] { DMAC_XS_A, DMAC_XS_B, DMAC_XS_RBUS } dmac_xsel_t;
    // Y source: 0/1 operand regs, 2 feedback, 3 same as X (square)
    typedef enum logic [1:0] { DMAC_YS_A, DMAC_YS_B, DMAC_YS_FB, DMAC_YS_SQR } dmac_ysel_t;

    // Register identifiers for moves to and from the data memory bus
    typedef enum logic [2:0] {
        DMAC_R_XA, DMAC_R_XB, DMAC_R_YA, DMAC_R_YB,
        DMAC_R_ACCL, DMAC_R_ACCM, DMAC_R_ACCG, DMAC_R_FB
    } dmac_reg_t;
endpackage

// file: dmac_if.sv
// Purpose: Carrier between the control top and the arithmetic core
// Assumes: Combinational core, driven by the top
// Notes: None
`timescale 1ns/1ps
interface dmac_if;
    logic [15:0] x_op;
    logic [15:0] y_op;
    logic x_signed;
    logic y_signed;
    logic int_mode;
    logic do_round;
    logic subtract;
    logic accumulate;
    logic [39:0] acc_in;
    logic [39:0] result;
    modport ctrl (output x_op, y_op, x_signed, y_signed, int_mode, do_round,
        subtract, accumulate, acc_in, input result);
    modport core (input x_op, y_op, x_signed, y_signed, int_mode, do_round,
        subtract, accumulate, acc_in, output result);
endinterface

// file: dmac_core.sv
// Purpose: Multiplier, alignment, adder/subtracter and rounding
// Assumes: Purely combinational
// Notes: Result wraps modulo the accumulator width
`timescale 1ns/1ps
module dmac_core
    import dmac_pkg::*;
(
    dmac_if.core bus
);
    logic signed [16:0] xs;
    logic signed [16:0] ys;
    logic signed [33:0] prod;
    logic [39:0] aligned;
    logic [39:0] sum;
    logic [39:0] rounded;

    always_comb begin
        // Extra bit selects signed or unsigned view of each operand
        xs = {bus.x_signed & bus.x_op[15], bus.x_op}; // [RQ20]
        ys = {bus.y_signed & bus.y_op[15], bus.y_op}; // [RQ20]
        prod = xs * ys; // [RQ1]
        if (bus.int_mode) begin
            aligned = {{6{prod[33]}}, prod[33:0]}; // [RQ19]
        end else begin
            aligned = {{5{prod[33]}}, prod[33:0], 1'b0}; // [RQ18]
        end
        if (!bus.accumulate) begin
            sum = aligned; // [RQ2]
        end else if (bus.subtract) begin
            sum = bus.acc_in - aligned; // [RQ25]
        end else begin
            sum = bus.acc_in + aligned; // [RQ25]
        end
        rounded = sum + DMAC_ROUND_ADD; // [RQ15]
        if (sum[15:0] == DMAC_ROUND_MID) begin
            rounded[16] = 1'b0; // [RQ23]
        end
        bus.result = bus.do_round ? rounded : sum;
    end
endmodule

// file: dmac_top.sv
// What this block does
// [RQ1] Multiply two 16-bit operands into a 32-bit product.
// [RQ2] Adder adds, subtracts or passes the product into the accumulator.
// [RQ3] Accumulator is low word, middle word and guard byte, each addressable.
// [RQ4] Overflow flag set when top nine accumulator bits differ.
// [RQ5] X operand from either X register or the result bus.
// [RQ6] Y operand from either Y register or the feedback register.
// [RQ7] Feedback destination stores result bits 16 to 31.
// [RQ8] Accumulator sections load from data bus, read onto data or result bus.
// [RQ9] Operand registers feed multiplier and data bus in one cycle.
// [RQ10] Y registers written from data or program bus, read toward both; code reads them onto data and result bus only, no program bus output.
// [RQ11] Registers read at cycle start, written at cycle end.
// [RQ12] Two register banks; mode bit zero selects, reset picks primary.
// [RQ13] Square uses one X register for both operands, with accumulate.
// [RQ14] Issuer gives a square unsigned, signed or round format.
// [RQ15] Round treats operands signed and rounds at bit 16.
// [RQ16] Multiply, square, multiply-add, multiply-subtract and clear are offered.
// [RQ17] Mode bit four picks integer alignment; reset picks fractional.
// [RQ18] Fractional product shifts left one, zero filling the LSB.
// [RQ19] Integer product is used without shifting.
// [RQ20] Each operand signed or unsigned independently.
// [RQ21] Middle word load sign-extends into guard; low load touches nothing else.
// [RQ22] Saturate forces extreme value when overflow set, chosen by guard MSB.
// [RQ23] Midpoint rounding forces result bit 16 to zero.
// [RQ24] Instruction carries operand format, changeable on every multiply.
// [RQ25] Accumulation wraps modulo two to the fortieth without saturation.
//
// Purpose: Multiply-accumulate unit with dual register bank
// Assumes: Command inputs are single-cycle and synchronous to clk
// Notes: Mode word written over its own mode_write/mode_wdata port, not the register port
`timescale 1ns/1ps
module dmac_top
    import dmac_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire dmac_op_t op_code,
    input wire dmac_xsel_t x_sel,
    input wire dmac_ysel_t y_sel,
    input wire logic x_signed,
    input wire logic y_signed,
    input wire logic round_option,
    input wire logic dest_feedback,
    input wire logic [15:0] result_bus_in,
    input wire logic dm_write,
    input wire dmac_reg_t dm_wr_reg,
    input wire logic [15:0] data_memory_bus_in,
    input wire logic dm_read,
    input wire dmac_reg_t dm_rd_reg,
    input wire logic pm_write,
    input wire logic pm_wr_sel,
    input wire logic [15:0] program_memory_bus_in,
    input wire logic rb_read,
    input wire dmac_reg_t rb_rd_reg,
    input wire logic mode_write,
    input wire logic [15:0] mode_wdata,
    output logic [15:0] data_memory_bus_out,
    output logic [15:0] result_bus_out,
    output logic [15:0] mode_control_word,
    output logic accum_overflow_flag,
    output logic [39:0] accumulator_result
);
    typedef struct packed {
        logic [15:0] x_operand_reg_a;
        logic [15:0] x_operand_reg_b;
        logic [15:0] y_operand_reg_a;
        logic [15:0] y_operand_reg_b;
        logic [15:0] feedback_register;
        logic [39:0] acc;
    } dmac_bank_t;

    typedef struct packed {
        dmac_bank_t bank0;
        dmac_bank_t bank1;
        logic [15:0] mode;
        logic ovf;
        logic [15:0] dm_out;
        logic [15:0] rb_out;
        logic [39:0] acc_view;
    } dmac_state_t;

    dmac_state_t st;
    dmac_state_t next_st;
    dmac_bank_t cur;
    dmac_bank_t nb;
    dmac_if mbus();

    dmac_core u_core (
        .bus(mbus.core)
    );

    function automatic logic top_nine_ovf(input logic [39:0] a);
        return !((&a[39:31]) || !(|a[39:31]));
    endfunction

    function automatic logic [15:0] read_reg(input dmac_bank_t b, input dmac_reg_t r);
        case (r)
            DMAC_R_XA: return b.x_operand_reg_a;
            DMAC_R_XB: return b.x_operand_reg_b;
            DMAC_R_YA: return b.y_operand_reg_a;
            DMAC_R_YB: return b.y_operand_reg_b;
            DMAC_R_ACCL: return b.acc[15:0];
            DMAC_R_ACCM: return b.acc[31:16];
            DMAC_R_ACCG: return {{8{b.acc[39]}}, b.acc[39:32]};
            DMAC_R_FB: return b.feedback_register;
            default: return 16'h0000;
        endcase
    endfunction

    logic alt_bank;
    logic is_arith;
    logic [15:0] x_val;
    logic [15:0] y_val;

    assign alt_bank = st.mode[DMAC_BANK_BIT]; // [RQ12]
    assign cur = alt_bank ? st.bank1 : st.bank0; // [RQ12]
    assign is_arith = op_valid && (op_code == DMAC_OP_MUL || op_code == DMAC_OP_MAC ||
        op_code == DMAC_OP_MSUB); // [RQ16]

    always_comb begin
        case (x_sel)
            DMAC_XS_A: x_val = cur.x_operand_reg_a; // [RQ5]
            DMAC_XS_B: x_val = cur.x_operand_reg_b; // [RQ5]
            DMAC_XS_RBUS: x_val = result_bus_in; // [RQ5]
            default: x_val = cur.x_operand_reg_a;
        endcase
        case (y_sel)
            DMAC_YS_A: y_val = cur.y_operand_reg_a; // [RQ6]
            DMAC_YS_B: y_val = cur.y_operand_reg_b; // [RQ6]
            DMAC_YS_FB: y_val = cur.feedback_register; // [RQ6]
            DMAC_YS_SQR: y_val = x_val; // [RQ13]
            default: y_val = cur.y_operand_reg_a;
        endcase
    end

    assign mbus.x_op = x_val;
    assign mbus.y_op = y_val;
    // Rounding forces a two's complement view of both operands
    assign mbus.x_signed = x_signed | round_option; // [RQ15]
    assign mbus.y_signed = (y_sel == DMAC_YS_SQR) ? (x_signed | round_option)
        : (y_signed | round_option); // [RQ13]
    assign mbus.int_mode = st.mode[DMAC_INT_BIT]; // [RQ17]
    assign mbus.do_round = round_option;
    assign mbus.subtract = (op_code == DMAC_OP_MSUB);
    assign mbus.accumulate = (op_code == DMAC_OP_MAC) || (op_code == DMAC_OP_MSUB);
    assign mbus.acc_in = cur.acc;

    always_comb begin
        next_st = st;
        nb = cur;
        // Moves read the old value; writes take effect at the clock edge
        next_st.dm_out = dm_read ? read_reg(cur, dm_rd_reg) : 16'h0000; // [RQ9] [RQ11]
        next_st.rb_out = rb_read ? read_reg(cur, rb_rd_reg) : 16'h0000; // [RQ8]
        if (dm_write) begin
            case (dm_wr_reg)
                DMAC_R_XA: nb.x_operand_reg_a = data_memory_bus_in;
                DMAC_R_XB: nb.x_operand_reg_b = data_memory_bus_in;
                DMAC_R_YA: nb.y_operand_reg_a = data_memory_bus_in; // [RQ10]
                DMAC_R_YB: nb.y_operand_reg_b = data_memory_bus_in; // [RQ10]
                DMAC_R_ACCL: nb.acc[15:0] = data_memory_bus_in; // [RQ21]
                DMAC_R_ACCM: nb.acc[39:16] = {{8{data_memory_bus_in[15]}},
                    data_memory_bus_in}; // [RQ21]
                DMAC_R_ACCG: nb.acc[39:32] = data_memory_bus_in[7:0]; // [RQ3] [RQ8]
                DMAC_R_FB: nb.feedback_register = data_memory_bus_in;
                default: nb = cur;
            endcase
        end
        if (pm_write) begin
            if (pm_wr_sel) begin
                nb.y_operand_reg_b = program_memory_bus_in; // [RQ10]
            end else begin
                nb.y_operand_reg_a = program_memory_bus_in; // [RQ10]
            end
        end
        if (op_valid) begin
            case (op_code)
                DMAC_OP_MUL, DMAC_OP_MAC, DMAC_OP_MSUB: begin
                    if (dest_feedback) begin
                        nb.feedback_register = mbus.result[31:16]; // [RQ7]
                    end else begin
                        nb.acc = mbus.result; // [RQ2]
                        next_st.ovf = top_nine_ovf(mbus.result); // [RQ4]
                    end
                end
                DMAC_OP_CLR: begin
                    nb.acc = 40'h0000000000; // [RQ16]
                    next_st.ovf = 1'b0;
                end
                DMAC_OP_SAT: begin
                    if (st.ovf) begin
                        nb.acc = cur.acc[39] ? DMAC_SAT_NEG : DMAC_SAT_POS; // [RQ22]
                    end
                end
                default: nb = nb;
            endcase
        end
        if (alt_bank) begin
            next_st.bank1 = nb;
        end else begin
            next_st.bank0 = nb;
        end
        if (mode_write) begin
            next_st.mode = mode_wdata;
        end
        next_st.acc_view = next_st.mode[DMAC_BANK_BIT] ? next_st.bank1.acc
            : next_st.bank0.acc; // [RQ12]
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.mode <= DMAC_MODE_RESET; // [RQ12] [RQ17]
        end else begin
            st <= next_st; // [RQ11]
        end
    end

    assign data_memory_bus_out = st.dm_out;
    assign result_bus_out = st.rb_out;
    assign mode_control_word = st.mode;
    assign accum_overflow_flag = st.ovf;
    assign accumulator_result = st.acc_view;

    property p_acc_update;
        @(posedge clk) disable iff (!reset_n)
        (is_arith && !dest_feedback) |=> (accumulator_result == $past(mbus.result)
            || $past(mode_write));
    endproperty
    a_acc_update: assert property (p_acc_update) else $error("acc not updated"); // [RQ2]

    property p_ovf;
        @(posedge clk) disable iff (!reset_n)
        (is_arith && !dest_feedback) |=> accum_overflow_flag ==
            !((&$past(mbus.result[39:31])) || !(|$past(mbus.result[39:31])));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong"); // [RQ4]

    property p_fb;
        @(posedge clk) disable iff (!reset_n)
        (is_arith && dest_feedback && !mode_write && !dm_write) ##1 (dm_read &&
            dm_rd_reg == DMAC_R_FB && !mode_write) |=> data_memory_bus_out ==
            $past(mbus.result[31:16], 2);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback wrong"); // [RQ7]

    property p_clr;
        @(posedge clk) disable iff (!reset_n)
        (op_valid && op_code == DMAC_OP_CLR && !mode_write) |=> accumulator_result == 40'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed"); // [RQ16]

    property p_midload;
        @(posedge clk) disable iff (!reset_n)
        (dm_write && dm_wr_reg == DMAC_R_ACCM && !op_valid && !mode_write) |=>
            accumulator_result[39:32] == {8{$past(data_memory_bus_in[15])}};
    endproperty
    a_midload: assert property (p_midload) else $error("guard not extended"); // [RQ21]

    property p_sat;
        @(posedge clk) disable iff (!reset_n)
        (op_valid && op_code == DMAC_OP_SAT && accum_overflow_flag && !mode_write) |=>
            (accumulator_result == DMAC_SAT_POS || accumulator_result == DMAC_SAT_NEG);
    endproperty
    a_sat: assert property (p_sat) else $error("saturate failed"); // [RQ22]

    property p_dmread;
        @(posedge clk) disable iff (!reset_n)
        (dm_read && dm_rd_reg == DMAC_R_ACCL) |=>
            data_memory_bus_out == $past(cur.acc[15:0]);
    endproperty
    a_dmread: assert property (p_dmread) else $error("read not old value"); // [RQ11]

    property p_mode;
        @(posedge clk) disable iff (!reset_n)
        mode_write |=> mode_control_word == $past(mode_wdata) ##1
            (mode_control_word == $past(mode_control_word) || $past(mode_write));
    endproperty
    a_mode: assert property (p_mode) else $error("mode word lost"); // [RQ12]

    property p_lowload;
        @(posedge clk) disable iff (!reset_n)
        (dm_write && dm_wr_reg == DMAC_R_ACCL && !op_valid && !mode_write) |=>
            accumulator_result[15:0] == $past(data_memory_bus_in) &&
            accumulator_result[39:16] == $past(accumulator_result[39:16]);
    endproperty
    a_lowload: assert property (p_lowload) else $error("low load spilled"); // [RQ21]

    property p_guardload;
        @(posedge clk) disable iff (!reset_n)
        (dm_write && dm_wr_reg == DMAC_R_ACCG && !op_valid && !mode_write) |=>
            accumulator_result[39:32] == $past(data_memory_bus_in[7:0]);
    endproperty
    a_guardload: assert property (p_guardload) else $error("guard load wrong"); // [RQ3]

    property p_rbread;
        @(posedge clk) disable iff (!reset_n)
        (rb_read && rb_rd_reg == DMAC_R_ACCG) |=>
            result_bus_out == {{8{$past(cur.acc[39])}}, $past(cur.acc[39:32])};
    endproperty
    a_rbread: assert property (p_rbread) else $error("guard read wrong"); // [RQ8]

    property p_idle;
        @(posedge clk) disable iff (!reset_n)
        !dm_read |=> data_memory_bus_out == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("data bus not idle"); // [RQ8]

    property p_pmload;
        @(posedge clk) disable iff (!reset_n)
        (pm_write && !mode_write) |=> $past(program_memory_bus_in) ==
            ($past(pm_wr_sel) ? cur.y_operand_reg_b : cur.y_operand_reg_a);
    endproperty
    a_pmload: assert property (p_pmload) else $error("program bus load lost"); // [RQ10]

    property p_sqr;
        @(posedge clk) disable iff (!reset_n)
        (is_arith && y_sel == DMAC_YS_SQR) |->
            mbus.y_op == mbus.x_op && mbus.y_signed == mbus.x_signed;
    endproperty
    a_sqr: assert property (p_sqr) else $error("square operands differ"); // [RQ13]

    property p_fbkeep;
        @(posedge clk) disable iff (!reset_n)
        (is_arith && dest_feedback && !dm_write && !mode_write) |=>
            accumulator_result == $past(accumulator_result) &&
            accum_overflow_flag == $past(accum_overflow_flag);
    endproperty
    a_fbkeep: assert property (p_fbkeep) else $error("feedback touched acc"); // [RQ7]

    property p_fracz;
        @(posedge clk) disable iff (!reset_n)
        (op_valid && op_code == DMAC_OP_MUL && !dest_feedback && !mbus.int_mode &&
            !mode_write) |=> !accumulator_result[0];
    endproperty
    a_fracz: assert property (p_fracz) else $error("fraction LSB not zero"); // [RQ18]

    c_mac: cover property (@(posedge clk) disable iff (!reset_n)
        op_valid && op_code == DMAC_OP_MAC ##1 op_valid && op_code == DMAC_OP_MAC);
    c_sqr: cover property (@(posedge clk) disable iff (!reset_n)
        is_arith && y_sel == DMAC_YS_SQR);
    c_alt: cover property (@(posedge clk) disable iff (!reset_n) alt_bank && is_arith);
    c_ovf: cover property (@(posedge clk) disable iff (!reset_n) $rose(accum_overflow_flag));
endmodule

// file: dmac_issuer.sv
// Purpose: Issuer model driving commands and moves into the unit
// Assumes: Signals change only right after a rising edge
// Notes: Released data lines show the inverse of their last value
`timescale 1ns/1ps
module dmac_issuer
    import dmac_pkg::*;
(
    input wire logic clk,
    output logic op_valid,
    output dmac_op_t op_code,
    output dmac_xsel_t x_sel,
    output dmac_ysel_t y_sel,
    output logic x_signed,
    output logic y_signed,
    output logic round_option,
    output logic dest_feedback,
    output logic [15:0] result_bus_in,
    output logic dm_write,
    output dmac_reg_t dm_wr_reg,
    output logic [15:0] data_memory_bus_in,
    output logic dm_read,
    output dmac_reg_t dm_rd_reg,
    output logic pm_write,
    output logic pm_wr_sel,
    output logic [15:0] program_memory_bus_in,
    output logic rb_read,
    output dmac_reg_t rb_rd_reg,
    output logic mode_write,
    output logic [15:0] mode_wdata,
    input wire logic [15:0] data_memory_bus_out,
    input wire logic [15:0] result_bus_out
);
    initial begin
        {op_valid, x_signed, y_signed, round_option, dest_feedback} = 5'h00;
        {dm_write, dm_read, pm_write, pm_wr_sel, rb_read, mode_write} = 6'h00;
        op_code = DMAC_OP_NONE;
        x_sel = DMAC_XS_A;
        y_sel = DMAC_YS_A;
        dm_wr_reg = DMAC_R_XA;
        dm_rd_reg = DMAC_R_XA;
        rb_rd_reg = DMAC_R_XA;
        {result_bus_in, data_memory_bus_in} = 32'h00000000;
        {program_memory_bus_in, mode_wdata} = 32'h00000000;
    end

    // Format travels with every instruction; squares always name one
    task automatic issue(input dmac_op_t c, input dmac_xsel_t xs, input dmac_ysel_t ys,
        input logic [1:0] sg, input logic rop, input logic fb, input logic [15:0] rb);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        x_sel <= xs;
        y_sel <= ys;
        {x_signed, y_signed} <= sg;
        round_option <= rop;
        dest_feedback <= fb;
        result_bus_in <= rb;
        @(posedge clk);
        op_valid <= 1'b0;
        result_bus_in <= ~rb;
        #1;
    endtask

    task automatic xfer(input logic w, input dmac_reg_t wr, input logic [15:0] wd,
        input logic r, input dmac_reg_t rr, output logic [15:0] dq, output logic [15:0] rq);
        @(posedge clk);
        dm_write <= w;
        dm_wr_reg <= wr;
        data_memory_bus_in <= wd;
        dm_read <= r;
        dm_rd_reg <= rr;
        rb_read <= r;
        rb_rd_reg <= rr;
        @(posedge clk);
        dm_write <= 1'b0;
        dm_read <= 1'b0;
        rb_read <= 1'b0;
        data_memory_bus_in <= ~wd;
        #1;
        dq = data_memory_bus_out;
        rq = result_bus_out;
    endtask

    task automatic pmw(input logic sel, input logic [15:0] d);
        @(posedge clk);
        pm_write <= 1'b1;
        pm_wr_sel <= sel;
        program_memory_bus_in <= d;
        @(posedge clk);
        pm_write <= 1'b0;
        program_memory_bus_in <= ~d;
        #1;
    endtask

    task automatic mode(input logic [15:0] d);
        @(posedge clk);
        mode_write <= 1'b1;
        mode_wdata <= d;
        @(posedge clk);
        mode_write <= 1'b0;
        mode_wdata <= ~d;
        #1;
    endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for the multiply-accumulate unit
// Assumes: Issuer model drives every input of the unit except clk and reset_n
// Notes: Expected values are worked out by hand from operand values
`timescale 1ns/1ps
module tb;
    import dmac_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic op_valid, x_signed, y_signed, round_option, dest_feedback, dm_write, dm_read;
    logic pm_write, pm_wr_sel, rb_read, mode_write, accum_overflow_flag;
    dmac_op_t op_code;
    dmac_xsel_t x_sel;
    dmac_ysel_t y_sel;
    dmac_reg_t dm_wr_reg, dm_rd_reg, rb_rd_reg;
    logic [15:0] result_bus_in, data_memory_bus_in, program_memory_bus_in, mode_wdata;
    logic [15:0] data_memory_bus_out, result_bus_out, mode_control_word, dq, rq;
    logic [39:0] accumulator_result;
    int fail_count = 0;
    int num_checks = 0;

    always #5 clk = ~clk;

    dmac_issuer u_dmac_issuer (.clk, .op_valid, .op_code, .x_sel, .y_sel, .x_signed,
        .y_signed, .round_option, .dest_feedback, .result_bus_in, .dm_write, .dm_wr_reg,
        .data_memory_bus_in, .dm_read, .dm_rd_reg, .pm_write, .pm_wr_sel,
        .program_memory_bus_in, .rb_read, .rb_rd_reg, .mode_write, .mode_wdata,
        .data_memory_bus_out, .result_bus_out);
    dmac_top u_dmac_top (.clk, .reset_n, .op_valid, .op_code, .x_sel, .y_sel, .x_signed,
        .y_signed, .round_option, .dest_feedback, .result_bus_in, .dm_write, .dm_wr_reg,
        .data_memory_bus_in, .dm_read, .dm_rd_reg, .pm_write, .pm_wr_sel,
        .program_memory_bus_in, .rb_read, .rb_rd_reg, .mode_write, .mode_wdata,
        .data_memory_bus_out, .result_bus_out, .mode_control_word, .accum_overflow_flag,
        .accumulator_result);

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input dmac_reg_t r, input logic [15:0] d);
        u_dmac_issuer.xfer(1'b1, r, d, 1'b0, DMAC_R_XA, dq, rq);
    endtask

    task automatic rd(input dmac_reg_t r);
        u_dmac_issuer.xfer(1'b0, DMAC_R_XA, 16'h0000, 1'b1, r, dq, rq);
    endtask

    task automatic op(input dmac_op_t c, input dmac_xsel_t xs, input dmac_ysel_t ys,
        input logic [1:0] sg, input logic rop);
        u_dmac_issuer.issue(c, xs, ys, sg, rop, 1'b0, 16'h0000);
    endtask

    task automatic t_reset();
        chk(mode_control_word, 40'h0000);
        chk(accumulator_result, 40'h0);
    endtask

    task automatic t_frac();
        wr(DMAC_R_XA, 16'h0003);
        wr(DMAC_R_YA, 16'h0002);
        op(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        chk(accumulator_result, 40'h000000000C);
    endtask

    task automatic t_int();
        u_dmac_issuer.mode(16'h0010);
        chk(mode_control_word, 40'h0010);
        op(DMAC_OP_MAC, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        chk(accumulator_result, 40'h0000000012);
        op(DMAC_OP_MSUB, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        chk(accumulator_result, 40'h000000000C);
    endtask

    task automatic t_square();
        wr(DMAC_R_XB, 16'hFFFF);
        op(DMAC_OP_MUL, DMAC_XS_B, DMAC_YS_SQR, 2'b00, 1'b0);
        chk(accumulator_result, 40'h00FFFE0001);
        chk(accum_overflow_flag, 40'h1);
        op(DMAC_OP_MAC, DMAC_XS_B, DMAC_YS_SQR, 2'b00, 1'b0);
        chk(accumulator_result, 40'h01FFFC0002);
        op(DMAC_OP_SAT, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        chk(accumulator_result, DMAC_SAT_POS);
        op(DMAC_OP_CLR, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        chk(accumulator_result, 40'h0);
        chk(accum_overflow_flag, 40'h0);
    endtask

    task automatic t_mixed();
        wr(DMAC_R_XA, 16'hFFFF);
        op(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_A, 2'b10, 1'b0);
        chk(accumulator_result, 40'hFFFFFFFFFE);
        op(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_A, 2'b01, 1'b0);
        chk(accumulator_result, 40'h000001FFFE);
    endtask

    task automatic t_wrap();
        wr(DMAC_R_ACCL, 16'hFFFF);
        wr(DMAC_R_ACCM, 16'hFFFF);
        wr(DMAC_R_ACCG, 16'h007F);
        chk(accumulator_result, 40'h7FFFFFFFFF);
        wr(DMAC_R_XA, 16'h0001);
        wr(DMAC_R_YA, 16'h0001);
        op(DMAC_OP_MAC, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        chk(accumulator_result, 40'h8000000000);
        chk(accum_overflow_flag, 40'h1);
        op(DMAC_OP_SAT, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        chk(accumulator_result, DMAC_SAT_NEG);
    endtask

    task automatic t_sect();
        wr(DMAC_R_ACCM, 16'h8000);
        wr(DMAC_R_ACCL, 16'h1234);
        chk(accumulator_result, 40'hFF80001234);
        rd(DMAC_R_ACCG);
        chk(dq, 40'hFFFF);
        chk(rq, 40'hFFFF);
        rd(DMAC_R_ACCM);
        chk(dq, 40'h8000);
        rd(DMAC_R_ACCL);
        chk(dq, 40'h1234);
    endtask

    task automatic t_round();
        u_dmac_issuer.mode(16'h0000);
        wr(DMAC_R_XA, 16'h4000);
        op(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b1);
        chk(accumulator_result[39:16], 40'h0);
        wr(DMAC_R_XA, 16'h4001);
        op(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b1);
        chk(accumulator_result[39:16], 40'h1);
    endtask

    task automatic t_fb();
        u_dmac_issuer.mode(16'h0010);
        op(DMAC_OP_CLR, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0);
        wr(DMAC_R_XA, 16'h0100);
        wr(DMAC_R_YA, 16'h0100);
        fork
            u_dmac_issuer.issue(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_A, 2'b11, 1'b0, 1'b1, 16'h0);
            begin
                @(posedge clk);
                rd(DMAC_R_FB);
            end
        join
        chk(accumulator_result, 40'h0);
        chk(dq, 40'h0001);
        op(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_FB, 2'b11, 1'b0);
        chk(accumulator_result, 40'h100);
    endtask

    task automatic t_src();
        u_dmac_issuer.issue(DMAC_OP_MUL, DMAC_XS_RBUS, DMAC_YS_A, 2'b11, 1'b0, 1'b0, 16'h3);
        chk(accumulator_result, 40'h300);
        u_dmac_issuer.pmw(1'b1, 16'h0005);
        fork
            op(DMAC_OP_MUL, DMAC_XS_A, DMAC_YS_B, 2'b11, 1'b0);
            rd(DMAC_R_YB);
        join
        chk(accumulator_result, 40'h500);
        chk(dq, 40'h0005);
    endtask

    task automatic t_bank();
        u_dmac_issuer.mode(16'h0011);
        chk(accumulator_result, 40'h0);
        wr(DMAC_R_XA, 16'h0007);
        u_dmac_issuer.mode(16'h0010);
        chk(accumulator_result, 40'h500);
        rd(DMAC_R_XA);
        chk(dq, 40'h0100);
    endtask

    task automatic t_same();
        u_dmac_issuer.xfer(1'b1, DMAC_R_XA, 16'h0222, 1'b1, DMAC_R_XA, dq, rq);
        chk(dq, 40'h0100);
        rd(DMAC_R_XA);
        chk(dq, 40'h0222);
    endtask

    initial begin
        #20000;
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        t_reset();
        t_frac();
        t_int();
        t_square();
        t_mixed();
        t_wrap();
        t_sect();
        t_round();
        t_fb();
        t_src();
        t_bank();
        t_same();
        complete_run();
    end
endmodule
